// ===== lane_sync_pkg.sv
`default_nettype none
package lane_sync_pkg;
    localparam int          ADDR_W         = 8;
    // byte addresses of the register window
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_CFG        = 8'h04;
    localparam logic [7:0]  REG_LINK       = 8'h08;
    localparam logic [7:0]  REG_IRQ_STAT   = 8'h0C;
    localparam logic [7:0]  REG_IRQ_MASK   = 8'h10;
    localparam logic [7:0]  REG_PHASE      = 8'h14;
    localparam logic [7:0]  REG_CMD        = 8'h18;
    localparam logic [7:0]  REG_ERR_BASE   = 8'h20;
    localparam logic [7:0]  REG_FLAG_BASE  = 8'h40;
    // control fields
    localparam int          CTRL_POLY_LSB  = 0;
    localparam int          CTRL_SCR_BIT   = 4;
    localparam int          CTRL_PROTO_BIT = 5;
    localparam int          CTRL_CTLE_LSB  = 8;
    localparam int          CTRL_LMASK_LSB = 12;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_F001;
    // cfg fields: lanes-1, converters-1, multiframe octets
    localparam int          CFG_L_LSB      = 0;
    localparam int          CFG_M_LSB      = 8;
    localparam int          CFG_MF_LSB     = 16;
    localparam logic [31:0] CFG_RESET      = 32'h0020_0103;
    // command bits
    localparam int          CMD_CLR_BIT    = 0;
    localparam int          CMD_LATCH_BIT  = 1;
    localparam int          CMD_CAL_BIT    = 2;
    // interrupt bits
    localparam int          IRQ_UP         = 0;
    localparam int          IRQ_ALIGN_FAIL = 1;
    localparam int          IRQ_DATA_FAULT = 2;
    localparam int          IRQ_PRBS_ERR   = 3;
    localparam int          IRQ_W          = 4;
    // pattern codes; the far-end field uses 5 for order 23 on lane 0 only (other lanes stay order 7) and any other value for order 7
    localparam logic [2:0]  POLY_7         = 3'h1;
    localparam logic [2:0]  POLY_9         = 3'h2;
    localparam logic [2:0]  POLY_15        = 3'h3;
    localparam logic [2:0]  POLY_23        = 3'h4;
    localparam logic [2:0]  POLY_31        = 3'h5;
    // control characters
    localparam logic [7:0]  K_COMMA        = 8'hBC;
    localparam logic [7:0]  K_MF_END       = 8'h7C;
    localparam logic [7:0]  K_CFG_START    = 8'h9C;
    localparam logic [2:0]  COMMA_RUN      = 3'h4;
    localparam logic [2:0]  ILAS_MF        = 3'h4;
    localparam logic [2:0]  FAIL_MF        = 3'h6;
    localparam logic [6:0]  PHASE_CENTRE   = 7'h00;
    localparam int          PHASE_STEPS    = 128;
    localparam int          EYE_MIN_STEPS  = 4;
    typedef enum logic [1:0] {ST_CGS, ST_ILAS, ST_DATA} link_state_e;
endpackage
`default_nettype wire

// ===== lane_sync_check.sv
`default_nettype none
module lane_sync_check #(
    parameter int LANES = 4,
    parameter int CNT_W = 32
) (
    // clock and reset
    input  wire logic                              i_core_clk,
    input  wire logic                              i_sys_rst,
    // register port
    input  wire logic [lane_sync_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [31:0]                       i_wr_data,
    input  wire logic                              i_wr_stb,
    input  wire logic                              i_rd_stb,
    output logic      [31:0]                       o_rd_data,
    // decoded lane octets from the deserialiser
    input  wire logic [LANES*8-1:0]                i_lane_data,
    input  wire logic [LANES-1:0]                  i_lane_is_k,
    input  wire logic [LANES-1:0]                  i_lane_valid,
    input  wire logic [LANES-1:0]                  i_lane_code_err,
    // link side
    output logic                                   o_sync_n,
    output logic [LANES*8-1:0]                     o_lane_data,
    output logic                                   o_data_phase,
    // analog front-end control
    output logic [6:0]                             o_sample_phase,
    output logic [LANES-1:0]                       o_phase_load,
    output logic [3:0]                             o_ctle_setting,
    // interrupt
    output logic                                   o_irq
);
    localparam int IRQ_W_T = lane_sync_pkg::IRQ_W;
    logic [31:0]              ctrl_q, cfg_q;
    logic [IRQ_W_T-1:0]       irq_stat_q, irq_mask_q;
    logic [6:0]               phase_q;
    lane_sync_pkg::link_state_e state_q;
    logic [2:0]               comma_run_q, mf_cnt_q, cfg_idx_q;
    logic [12:0]              ilas_oct_q;
    logic                     cfg_bad_q;
    logic [CNT_W-1:0]         err_cnt_q [LANES];
    logic [2:0]               flags_q [LANES];
    logic [LANES-1:0]         prbs_err, prbs_inv;
    logic [31:0]              rd_d;

    wire wr_cmd = i_wr_stb && i_addr == lane_sync_pkg::REG_CMD;
    wire clr_cmd = wr_cmd && i_wr_data[lane_sync_pkg::CMD_CLR_BIT];
    wire [LANES-1:0] lmask = ctrl_q[lane_sync_pkg::CTRL_LMASK_LSB +: LANES];
    wire [2:0] poly = ctrl_q[lane_sync_pkg::CTRL_POLY_LSB +: 3];
    wire [9:0] mf_len = cfg_q[lane_sync_pkg::CFG_MF_LSB +: 10];
    // six multiframes of octets, the ceiling on a failing alignment
    wire [12:0] fail_oct = 13'(mf_len) * 13'(lane_sync_pkg::FAIL_MF);

    // per-lane comma detection, all enabled lanes must agree
    logic [LANES-1:0] is_comma, is_mf_end, lane_bad;
    for (genvar l = 0; l < LANES; l++) begin : g_det
        assign is_comma[l]  = !lmask[l] || (i_lane_valid[l] && i_lane_is_k[l]
                              && i_lane_data[l*8 +: 8] == lane_sync_pkg::K_COMMA);
        assign is_mf_end[l] = i_lane_is_k[l] && i_lane_data[l*8 +: 8] == lane_sync_pkg::K_MF_END;
        assign lane_bad[l]  = lmask[l] && (!i_lane_valid[l] || i_lane_code_err[l]);
    end
    wire lead_k = i_lane_is_k[0];
    wire [7:0] lead_oct = i_lane_data[7:0];

    // link state machine; the far end keeps streaming commas, then alignment
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_q     <= lane_sync_pkg::ST_CGS;
            o_sync_n    <= 1'b0;
            o_data_phase <= 1'b0;
            comma_run_q <= 3'h0;
            mf_cnt_q    <= 3'h0;
            cfg_idx_q   <= 3'h0;
            ilas_oct_q  <= 13'h0;
            cfg_bad_q   <= 1'b0;
        end else begin
            case (state_q)
                lane_sync_pkg::ST_CGS: begin
                    o_sync_n <= 1'b0;
                    if (&is_comma && comma_run_q == lane_sync_pkg::COMMA_RUN - 3'h1) begin
                        state_q    <= lane_sync_pkg::ST_ILAS;
                        o_sync_n   <= 1'b1;
                        mf_cnt_q   <= 3'h0;
                        cfg_idx_q  <= 3'h0;
                        ilas_oct_q <= 13'h0;
                        cfg_bad_q  <= 1'b0;
                    end
                    comma_run_q <= &is_comma ? comma_run_q + 3'h1 : 3'h0;
                end
                lane_sync_pkg::ST_ILAS: begin
                    ilas_oct_q <= ilas_oct_q + 13'h1;
                    if (is_mf_end[0])
                        mf_cnt_q <= mf_cnt_q + 3'h1;
                    // second multiframe carries the link parameters
                    if (mf_cnt_q == 3'h1 && lead_k && lead_oct == lane_sync_pkg::K_CFG_START) begin
                        cfg_idx_q <= 3'h1;
                    end else if (cfg_idx_q == 3'h1) begin
                        cfg_idx_q <= 3'h2;
                        if (lead_oct[4:0] != cfg_q[lane_sync_pkg::CFG_L_LSB +: 5])
                            cfg_bad_q <= 1'b1;
                    end else if (cfg_idx_q == 3'h2) begin
                        cfg_idx_q <= 3'h3;
                        if (lead_oct != cfg_q[lane_sync_pkg::CFG_M_LSB +: 8])
                            cfg_bad_q <= 1'b1;
                    end
                    // compare on count plus one so a zero multiframe length fails at once
                    if (cfg_bad_q || |lane_bad || ilas_oct_q + 13'h1 >= fail_oct) begin
                        state_q     <= lane_sync_pkg::ST_CGS;
                        o_sync_n    <= 1'b0;
                        comma_run_q <= 3'h0;
                    end else if (is_mf_end[0] && mf_cnt_q == lane_sync_pkg::ILAS_MF - 3'h1
                                 && cfg_idx_q == 3'h3) begin
                        state_q      <= lane_sync_pkg::ST_DATA;
                        o_data_phase <= 1'b1;
                    end
                end
                lane_sync_pkg::ST_DATA: begin
                    if (|lane_bad) begin
                        state_q     <= lane_sync_pkg::ST_CGS;
                        o_sync_n    <= 1'b0;
                        o_data_phase <= 1'b0;
                        comma_run_q <= 3'h0;
                    end
                end
                default: begin
                    state_q      <= lane_sync_pkg::ST_CGS;
                    o_sync_n     <= 1'b0;
                    o_data_phase <= 1'b0;
                end
            endcase
        end
    end

    // pattern checker taps, self-synchronising on the received stream
    function automatic logic [9:0] taps(input logic [2:0] sel);
        case (sel)
            lane_sync_pkg::POLY_9:  taps = {5'h08, 5'h04};
            lane_sync_pkg::POLY_15: taps = {5'h0E, 5'h0D};
            lane_sync_pkg::POLY_23: taps = {5'h16, 5'h11};
            lane_sync_pkg::POLY_31: taps = {5'h1E, 5'h1B};
            default:                taps = {5'h06, 5'h05};
        endcase
    endfunction
    wire [9:0] tp = taps(poly);

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [30:0] hist_q, hist_d;
        logic [14:0] scr_q, scr_d;
        logic [7:0]  mism, dscr;
        always_comb begin
            logic [30:0] h;
            logic [14:0] s;
            h = hist_q;
            s = scr_q;
            mism = 8'h00;
            dscr = 8'h00;
            for (int b = 7; b >= 0; b--) begin
                mism[b] = i_lane_data[l*8+b] ^ h[tp[9:5]] ^ h[tp[4:0]];
                h = {h[29:0], i_lane_data[l*8+b]};
                dscr[b] = i_lane_data[l*8+b] ^ s[14] ^ s[13];
                s = {s[13:0], i_lane_data[l*8+b]};
            end
            hist_d = h;
            scr_d  = s;
        end
        // inverted stream mismatches on every bit and is not counted
        assign prbs_inv[l] = mism == 8'hFF;
        assign prbs_err[l] = lmask[l] && i_lane_valid[l] && |mism && !prbs_inv[l];

        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
                hist_q <= 31'h0;
                scr_q  <= 15'h0;
            end else if (i_lane_valid[l]) begin
                hist_q <= hist_d;
                scr_q  <= scr_d;
            end
        end
        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst)
                o_lane_data[l*8 +: 8] <= 8'h00;
            else if (ctrl_q[lane_sync_pkg::CTRL_SCR_BIT] && o_data_phase)
                o_lane_data[l*8 +: 8] <= dscr;
            else
                o_lane_data[l*8 +: 8] <= i_lane_data[l*8 +: 8];
        end
        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst || clr_cmd)
                err_cnt_q[l] <= '0;
            else if (prbs_err[l] && err_cnt_q[l] != {CNT_W{1'b1}})
                err_cnt_q[l] <= err_cnt_q[l] + 1'b1;
        end
        // sticky error flag: a fresh error beats a simultaneous clear
        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst)
                flags_q[l] <= 3'h0;
            else begin
                flags_q[l][0] <= !clr_cmd && lmask[l] && i_lane_valid[l] && prbs_inv[l];
                flags_q[l][1] <= !clr_cmd && lane_bad[l];
                flags_q[l][2] <= (flags_q[l][2] && !clr_cmd) || prbs_err[l];
            end
        end
    end

    // register writes; cfg must match the far end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ctrl_q     <= lane_sync_pkg::CTRL_RESET;
            cfg_q      <= lane_sync_pkg::CFG_RESET;
            irq_mask_q <= '0;
            phase_q    <= lane_sync_pkg::PHASE_CENTRE;
        end else if (i_wr_stb) begin
            case (i_addr)
                lane_sync_pkg::REG_CTRL:     ctrl_q     <= i_wr_data;
                lane_sync_pkg::REG_CFG:      cfg_q      <= i_wr_data;
                lane_sync_pkg::REG_IRQ_MASK: irq_mask_q <= i_wr_data[IRQ_W_T-1:0];
                lane_sync_pkg::REG_PHASE:    phase_q    <= i_wr_data[6:0];
                default: ;
            endcase
        end
    end

    // phase latch and calibration; software sweeps and judges the eye
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_sample_phase <= lane_sync_pkg::PHASE_CENTRE;
            o_phase_load   <= '0;
            o_ctle_setting <= 4'h0;
        end else begin
            o_phase_load <= '0;
            if (wr_cmd && i_wr_data[lane_sync_pkg::CMD_CAL_BIT]
                && ctrl_q[lane_sync_pkg::CTRL_PROTO_BIT]) begin
                o_ctle_setting <= ctrl_q[lane_sync_pkg::CTRL_CTLE_LSB +: 4];
                o_sample_phase <= lane_sync_pkg::PHASE_CENTRE;
                o_phase_load   <= lmask;
            end else if (wr_cmd && i_wr_data[lane_sync_pkg::CMD_LATCH_BIT]) begin
                o_sample_phase <= phase_q;
                o_phase_load   <= i_wr_data[8 +: LANES];
            end
        end
    end

    // interrupts: set beats a simultaneous write-one clear
    logic [IRQ_W_T-1:0] irq_set;
    always_comb begin
        irq_set = '0;
        irq_set[lane_sync_pkg::IRQ_UP] = state_q == lane_sync_pkg::ST_ILAS && state_q != lane_sync_pkg::ST_DATA
            && is_mf_end[0] && mf_cnt_q == lane_sync_pkg::ILAS_MF - 3'h1 && cfg_idx_q == 3'h3
            && !cfg_bad_q && !(|lane_bad) && ilas_oct_q + 13'h1 < fail_oct;
        irq_set[lane_sync_pkg::IRQ_ALIGN_FAIL] = state_q == lane_sync_pkg::ST_ILAS
            && (cfg_bad_q || |lane_bad || ilas_oct_q + 13'h1 >= fail_oct);
        irq_set[lane_sync_pkg::IRQ_DATA_FAULT] = o_data_phase && |lane_bad;
        irq_set[lane_sync_pkg::IRQ_PRBS_ERR] = |prbs_err;
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            irq_stat_q <= '0;
            o_irq      <= 1'b0;
        end else begin
            if (i_wr_stb && i_addr == lane_sync_pkg::REG_IRQ_STAT)
                irq_stat_q <= (irq_stat_q & ~i_wr_data[IRQ_W_T-1:0]) | irq_set;
            else
                irq_stat_q <= irq_stat_q | irq_set;
            o_irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read mux, unmapped reads as zero
    always_comb begin
        rd_d = 32'h0;
        case (i_addr)
            lane_sync_pkg::REG_CTRL:     rd_d = ctrl_q;
            lane_sync_pkg::REG_CFG:      rd_d = cfg_q;
            lane_sync_pkg::REG_LINK:     rd_d = {29'h0, o_sync_n, 2'(state_q)};
            lane_sync_pkg::REG_IRQ_STAT: rd_d = 32'(irq_stat_q);
            lane_sync_pkg::REG_IRQ_MASK: rd_d = 32'(irq_mask_q);
            lane_sync_pkg::REG_PHASE:    rd_d = {25'h0, phase_q};
            default: begin
                for (int l = 0; l < LANES; l++) begin
                    if (i_addr == lane_sync_pkg::REG_ERR_BASE + 8'(4*l))
                        rd_d = 32'(err_cnt_q[l]);
                    if (i_addr == lane_sync_pkg::REG_FLAG_BASE + 8'(4*l))
                        rd_d = {29'h0, flags_q[l]};
                end
            end
        endcase
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)
            o_rd_data <= 32'h0;
        else if (i_rd_stb)
            o_rd_data <= rd_d;
        else
            o_rd_data <= 32'h0;
    end

    AST_SYNC_LOW_CGS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        state_q == lane_sync_pkg::ST_CGS |-> !o_sync_n) else $error("request high in sync phase");
    AST_RELEASE_RUN: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_sync_n) |-> $past(comma_run_q) == 3'h3 && $past(&is_comma)) else $error("early release");
    AST_FAIL_BOUND: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        state_q == lane_sync_pkg::ST_ILAS |-> ilas_oct_q < fail_oct) else $error("alignment overran");
    AST_MISMATCH: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        state_q == lane_sync_pkg::ST_ILAS && cfg_bad_q |=> state_q == lane_sync_pkg::ST_CGS && !o_sync_n)
        else $error("mismatch reached data");
    AST_DATA_FAULT: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_data_phase && |lane_bad |=> state_q == lane_sync_pkg::ST_CGS ##1 !o_sync_n)
        else $error("fault did not resync");
    AST_CNT_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        clr_cmd |=> err_cnt_q[0] == '0 && flags_q[0][1:0] == 2'h0 && flags_q[0][2] == $past(prbs_err[0]))
        else $error("clear failed");
    AST_CNT_INC: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        prbs_err[0] && !clr_cmd && err_cnt_q[0] < 32'(CNT_W'(100)) |=> err_cnt_q[0] == $past(err_cnt_q[0]) + 1'b1)
        else $error("counter missed error");
    AST_FLAG_ERR: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        prbs_err[0] |=> flags_q[0][2]) else $error("lane error flag missing");
    AST_FLAG_STICKY: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        flags_q[0][2] && !clr_cmd |=> flags_q[0][2]) else $error("lane error flag dropped");
    AST_PHASE_LATCH: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        wr_cmd && i_wr_data[lane_sync_pkg::CMD_LATCH_BIT] && !i_wr_data[lane_sync_pkg::CMD_CAL_BIT]
        |=> o_sample_phase == $past(phase_q) && o_phase_load == $past(i_wr_data[8 +: LANES]))
        else $error("phase not latched");
    AST_DEFAULT_POLY: assert property (@(posedge i_core_clk)
        $fell(i_sys_rst) |-> poly == lane_sync_pkg::POLY_7) else $error("default pattern not order 7");
    AST_IRQ: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        ##1 o_irq == $past(|(irq_stat_q & irq_mask_q))) else $error("irq mismatch");
endmodule
`default_nettype wire

// ===== far_end_framer.sv
`default_nettype none
module far_end_framer #(
    parameter int LANES = 2,
    parameter int MF    = 8
) (
    // clock
    input  wire logic               i_core_clk,
    // stimulus: 0 idle, 1 comma, 2 alignment, 3 pattern, 4 corrupt
    input  wire logic [2:0]         i_mode,
    input  wire logic [31:0]        i_gen_ctrl,
    input  wire logic               i_bad_cfg,
    // lanes
    output logic      [LANES*8-1:0] o_lane_data,
    output logic      [LANES-1:0]   o_lane_is_k,
    output logic      [LANES-1:0]   o_lane_valid,
    output logic      [LANES-1:0]   o_lane_code_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] oct_q = 16'h0;
    logic [6:0]  p7    = 7'h7F;
    logic [22:0] p23   = 23'h7FFFFF;
    logic [7:0]  a7;
    logic [7:0]  a23;
    initial o_lane_data = '0;
    always @(posedge i_core_clk) begin
        o_lane_is_k     <= '0;
        o_lane_valid    <= '1;
        o_lane_code_err <= '0;
        oct_q           <= 16'h0;
        case (i_mode)
            3'h1: begin
                o_lane_data <= {LANES{lane_sync_pkg::K_COMMA}};
                o_lane_is_k <= '1;
            end
            3'h2: begin
                oct_q       <= oct_q + 16'h1;
                o_lane_data <= {LANES{oct_q[7:0]}};
                if ((oct_q % MF) == MF - 1 && oct_q < 4 * MF) begin
                    o_lane_data <= {LANES{lane_sync_pkg::K_MF_END}};
                    o_lane_is_k <= '1;
                end else if (oct_q == MF) begin
                    o_lane_data <= {LANES{lane_sync_pkg::K_CFG_START}};
                    o_lane_is_k <= '1;
                end else if (oct_q == MF + 1) begin
                    o_lane_data <= {LANES{8'(LANES - 1) ^ {7'h00, i_bad_cfg}}};
                end else if (oct_q == MF + 2) begin
                    o_lane_data <= {LANES{8'h01}};
                end
            end
            3'h3: begin
                for (int b = 7; b >= 0; b--) begin
                    a7[b]  = p7[6] ^ p7[5];
                    p7     = {p7[5:0], a7[b]};
                    a23[b] = p23[22] ^ p23[17];
                    p23    = {p23[21:0], a23[b]};
                end
                o_lane_data <= {LANES{a7}};
                if (i_gen_ctrl[27:24] == 4'h5) begin
                    o_lane_data[7:0] <= a23;
                end
            end
            3'h4: begin
                o_lane_data     <= ~o_lane_data;
                o_lane_code_err <= '1;
            end
            default: begin
                // released lanes toggle so stale data never looks valid
                o_lane_data  <= ~o_lane_data;
                o_lane_valid <= '0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LANES = 2;
    localparam int MF    = 8;
    logic               i_core_clk = 1'b0;
    logic               i_sys_rst  = 1'b1;
    logic [7:0]         i_addr     = 8'h00;
    logic [31:0]        i_wr_data  = 32'h0;
    logic               i_wr_stb   = 1'b0;
    logic               i_rd_stb   = 1'b0;
    logic [31:0]        o_rd_data;
    logic [LANES*8-1:0] lane_in;
    logic [LANES-1:0]   is_k;
    logic [LANES-1:0]   lane_ok;
    logic [LANES-1:0]   code_err;
    logic [LANES*8-1:0] o_lane_data;
    logic               o_sync_n;
    logic               o_data_phase;
    logic [6:0]         o_sample_phase;
    logic [LANES-1:0]   o_phase_load;
    logic [3:0]         o_ctle_setting;
    logic               o_irq;
    logic [2:0]         mode     = 3'h0;
    logic [31:0]        gen_ctrl = 32'h0100_0000;
    logic               bad_cfg  = 1'b0;
    logic [LANES-1:0]   loads    = '0;
    logic [31:0]        d;
    int                 errors   = 0;
    int                 compares = 0;
    int                 cycles   = 0;
    lane_sync_check #(.LANES(LANES), .CNT_W(32)) u_lane_sync_check (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_lane_data(lane_in),
        .i_lane_is_k(is_k), .i_lane_valid(lane_ok), .i_lane_code_err(code_err), .o_sync_n(o_sync_n),
        .o_lane_data(o_lane_data), .o_data_phase(o_data_phase), .o_sample_phase(o_sample_phase),
        .o_phase_load(o_phase_load), .o_ctle_setting(o_ctle_setting), .o_irq(o_irq));
    far_end_framer #(.LANES(LANES), .MF(MF)) u_far_end_framer (
        .i_core_clk(i_core_clk), .i_mode(mode), .i_gen_ctrl(gen_ctrl), .i_bad_cfg(bad_cfg),
        .o_lane_data(lane_in), .o_lane_is_k(is_k), .o_lane_valid(lane_ok), .o_lane_code_err(code_err));
    always #4 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cycles = cycles + 1;
        loads <= loads | o_phase_load;
        if (cycles == 20000) begin
            errors = errors + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_core_clk);
        i_addr    <= a;
        i_wr_data <= v;
        i_wr_stb  <= 1'b1;
        @(posedge i_core_clk);
        i_wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_core_clk);
        i_addr   <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_core_clk);
        i_rd_stb <= 1'b0;
        #1 d = o_rd_data;
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check(n, d, e);
    endtask
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        for (int n = 0; n < lim && s !== v; n++) @(posedge i_core_clk);
        #1;
    endtask
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        rc("link", lane_sync_pkg::REG_LINK, 32'h0);
        rc("ctrl", lane_sync_pkg::REG_CTRL, lane_sync_pkg::CTRL_RESET);
        rc("cfg", lane_sync_pkg::REG_CFG, lane_sync_pkg::CFG_RESET);
        rc("unmapped", 8'hFC, 32'h0);
        wr(lane_sync_pkg::REG_CFG, 32'h0008_0101);
        wr(lane_sync_pkg::REG_CTRL, 32'h0000_3001);
        wr(lane_sync_pkg::REG_IRQ_MASK, 32'h1);
        mode <= 3'h1;
        repeat (3) @(posedge i_core_clk);
        mode <= 3'h0;
        repeat (4) @(posedge i_core_clk);
        check("sync_n three commas", o_sync_n, 1'b0);
        mode <= 3'h1;
        wait_sig(o_sync_n, 1'b1, 12);
        check("sync_n four commas", o_sync_n, 1'b1);
        rc("link align", lane_sync_pkg::REG_LINK, 32'h5);
        mode <= 3'h2;
        wait_sig(o_data_phase, 1'b1, 5 * MF);
        check("data phase", o_data_phase, 1'b1);
        mode <= 3'h3;
        repeat (2) @(posedge i_core_clk);
        check("irq up", o_irq, 1'b1);
        rd(lane_sync_pkg::REG_IRQ_STAT);
        check("stat up", d[0], 1'b1);
        wr(lane_sync_pkg::REG_IRQ_STAT, 32'h1);
        repeat (3) @(posedge i_core_clk);
        check("irq cleared", o_irq, 1'b0);
        wr(lane_sync_pkg::REG_CMD, 32'h1);
        repeat (40) @(posedge i_core_clk);
        rc("err0 same poly", lane_sync_pkg::REG_ERR_BASE, 32'h0);
        rc("flag0 same poly", lane_sync_pkg::REG_FLAG_BASE, 32'h0);
        @(posedge i_core_clk);
        d = 32'(lane_in);
        #1 check("lane data", 32'(o_lane_data), d);
        gen_ctrl <= 32'h0500_0000;
        wr(lane_sync_pkg::REG_CMD, 32'h1);
        repeat (40) @(posedge i_core_clk);
        rd(lane_sync_pkg::REG_ERR_BASE);
        check("err0 mismatch", 32'(d != 0), 32'h1);
        rc("err1 clean", lane_sync_pkg::REG_ERR_BASE + 8'h04, 32'h0);
        rd(lane_sync_pkg::REG_FLAG_BASE);
        check("flag0 error", d[2], 1'b1);
        rc("flag1", lane_sync_pkg::REG_FLAG_BASE + 8'h04, 32'h0);
        wr(lane_sync_pkg::REG_PHASE, 32'h7F);
        wr(lane_sync_pkg::REG_CMD, 32'h0000_0202);
        repeat (2) @(posedge i_core_clk);
        check("load lane1", loads, 2'b10);
        check("phase", o_sample_phase, 7'h7F);
        wr(lane_sync_pkg::REG_CTRL, 32'h0000_3521);
        wr(lane_sync_pkg::REG_CMD, 32'h4);
        repeat (2) @(posedge i_core_clk);
        check("ctle", o_ctle_setting, 4'h5);
        check("cal phase", o_sample_phase, 7'h00);
        check("cal load", loads, 2'b11);
        mode <= 3'h4;
        wait_sig(o_sync_n, 1'b0, 10);
        check("fault sync_n", o_sync_n, 1'b0);
        check("fault phase", o_data_phase, 1'b0);
        rd(lane_sync_pkg::REG_IRQ_STAT);
        check("stat fault", d[2], 1'b1);
        mode    <= 3'h1;
        bad_cfg <= 1'b1;
        wait_sig(o_sync_n, 1'b1, 12);
        check("resync", o_sync_n, 1'b1);
        mode <= 3'h2;
        wait_sig(o_sync_n, 1'b0, 6 * MF + 4);
        check("bad cfg sync_n", o_sync_n, 1'b0);
        check("bad cfg phase", o_data_phase, 1'b0);
        rd(lane_sync_pkg::REG_IRQ_STAT);
        check("stat align fail", d[1], 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
